// ===== mwd_defines.vh
// Register map, field positions and reset values of the motion-wake detector
`ifndef MWD_DEFINES_VH
`define MWD_DEFINES_VH

`define MWD_ADDR_HIDDEN_DATA 8'h13
`define MWD_ADDR_CONFIG 8'h14
`define MWD_CONFIG_RESET 8'h00
`define MWD_HIDDEN_RESET 6'h00
`define MWD_MODES_RESET 2'h0

`define MWD_PTR_LSB 0
`define MWD_PTR_MSB 2
`define MWD_CNTEN_BIT 3
`define MWD_SLICE_LSB 4
`define MWD_SLICE_MSB 6
`define MWD_DETRST_BIT 7

`define MWD_DATA_LSB 0
`define MWD_DATA_MSB 5
`define MWD_COMBINE_BIT 6
`define MWD_DELTA_MODE_BIT 7

`define MWD_PTR_THR_BASE 3'h1
`define MWD_PTR_CNT_BASE 3'h5
`define MWD_SLICE_TOP 3'h5
`define MWD_DELTA_MAX 11'h7ff
`define MWD_SLICE_MAX 6'h3f
`define MWD_RUN_RESET 6'h00
`define MWD_RUN_MAX 6'h3f
`define MWD_WAKE_RESET 1'b0
`define MWD_RD_RESET 8'h00
`define MWD_RD_IDLE 8'h00

`define MWD_PTR_THR_X 3'h1
`define MWD_PTR_THR_Y 3'h2
`define MWD_PTR_THR_Z 3'h3
`define MWD_PTR_CNT_X 3'h5
`define MWD_PTR_CNT_Y 3'h6
`define MWD_PTR_CNT_Z 3'h7

`endif

// ===== mwd_motion_wake.v
// Motion-wake detector: configuration register, hidden threshold/count registers and detection logic
`timescale 1ns/1ps
`include "mwd_defines.vh"
// Notes on behaviour
// RULE1: Pointer picks threshold or count hidden register
// RULE2: Counter-enable bit gates all axis counters
// RULE3: No wakeup while counting disabled
// RULE4: Slice code picks six delta bits
// RULE5: Oversized delta clamps to full scale
// RULE6: Detector reset bit never self-clears
// RULE7: Reset bit high holds detector in reset
// RULE8: Host re-arms by pulsing detector reset
// RULE9: Human motion: threshold three recommended
// RULE10: Tap: threshold 28, slice zero recommended
// RULE11: Per-axis independent six-bit unsigned thresholds
// RULE12: Count register holds events minus one
// RULE13: Combine bit: any axis or all axes
// RULE14: Delta mode: previous sample or baseline
// RULE15: Detector reset clears counters, baseline, wake
module mwd_motion_wake #(
    parameter SAMPLE_W = 12
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire reset_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_en_in,
    input wire [7:0] reg_wr_data_in,
    output wire [7:0] reg_rd_data_out,
    // Samples, packed x in the low slice
    input wire sample_valid_in,
    input wire [3*SAMPLE_W-1:0] sample_in,
    // Wake event, held until the detector reset is applied
    output wire motion_wake_out
);

////////////////////////////////////////////////////////////////////////////////
// Configuration and mode registers

reg [7:0] config_q;
reg combine_all_q;
reg delta_baseline_q;
reg [7:0] rd_data_q;
reg wake_q;
wire wr_cfg = reg_wr_en_in && (reg_addr_in == `MWD_ADDR_CONFIG);
wire wr_hid = reg_wr_en_in && (reg_addr_in == `MWD_ADDR_HIDDEN_DATA);
wire [2:0] hidden_reg_pointer = config_q[`MWD_PTR_MSB:`MWD_PTR_LSB];
wire event_counter_enable = config_q[`MWD_CNTEN_BIT];
wire [2:0] slice_sel = config_q[`MWD_SLICE_MSB:`MWD_SLICE_LSB];
wire det_rst = config_q[`MWD_DETRST_BIT];

reg [7:0] config_d;
reg combine_all_d;
reg delta_baseline_d;
always @* begin
    config_d = config_q;
    combine_all_d = combine_all_q;
    delta_baseline_d = delta_baseline_q;
    // Only a host write changes the reset bit; nothing here clears it
    if (wr_cfg) begin
        config_d = reg_wr_data_in; // RULE6
    end
    if (wr_hid) begin
        combine_all_d = reg_wr_data_in[`MWD_COMBINE_BIT]; // RULE13
        delta_baseline_d = reg_wr_data_in[`MWD_DELTA_MODE_BIT]; // RULE14
    end
end

always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
        config_q <= `MWD_CONFIG_RESET;
        {combine_all_q, delta_baseline_q} <= `MWD_MODES_RESET;
    end else begin
        config_q <= config_d;
        combine_all_q <= combine_all_d;
        delta_baseline_q <= delta_baseline_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-axis hidden registers and detection

wire [2:0] axis_hit;
wire [17:0] thr_flat;
wire [17:0] cnt_flat;
wire [2:0] slice_shift = (slice_sel >= `MWD_SLICE_TOP) ? `MWD_SLICE_TOP : slice_sel; // RULE4

genvar a;
generate
    for (a = 0; a < 3; a = a + 1) begin : g_axis
        reg [5:0] thr_q;
        reg [5:0] need_q;
        reg [5:0] run_q;
        reg [SAMPLE_W-1:0] ref_q;
        reg have_ref_q;
        reg [5:0] run_d;
        localparam [31:0] THR_CODE = `MWD_PTR_THR_BASE + a;
        localparam [31:0] CNT_CODE = `MWD_PTR_CNT_BASE + a;
        wire [SAMPLE_W-1:0] cur = sample_in[a*SAMPLE_W +: SAMPLE_W];
        wire [SAMPLE_W:0] diff = {cur[SAMPLE_W-1], cur} - {ref_q[SAMPLE_W-1], ref_q};
        wire [SAMPLE_W:0] mag = diff[SAMPLE_W] ? (~diff + 1'b1) : diff;
        wire [10:0] delta = (mag > {{(SAMPLE_W-10){1'b0}}, `MWD_DELTA_MAX}) ? `MWD_DELTA_MAX : mag[10:0];
        wire [10:0] shifted = delta >> slice_shift;
        // Bits above the slice saturate it rather than wrap it
        wire [5:0] slice = (shifted > {5'h00, `MWD_SLICE_MAX}) ? `MWD_SLICE_MAX : shifted[5:0]; // RULE5
        wire qual = have_ref_q && (slice > thr_q); // RULE11
        wire step = sample_valid_in && event_counter_enable; // RULE2
        assign axis_hit[a] = step && qual && (run_q >= need_q); // RULE12
        assign thr_flat[a*6 +: 6] = thr_q;
        assign cnt_flat[a*6 +: 6] = need_q;

        always @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
                thr_q <= `MWD_HIDDEN_RESET;
                need_q <= `MWD_HIDDEN_RESET;
            end else if (wr_hid) begin
                if (hidden_reg_pointer == THR_CODE[2:0]) begin
                    thr_q <= reg_wr_data_in[`MWD_DATA_MSB:`MWD_DATA_LSB]; // RULE1
                end
                if (hidden_reg_pointer == CNT_CODE[2:0]) begin
                    need_q <= reg_wr_data_in[`MWD_DATA_MSB:`MWD_DATA_LSB]; // RULE1
                end
            end
        end

        // A sample that fails the threshold restarts the run, so counts are consecutive
        always @* begin
            run_d = run_q;
            if (det_rst) begin
                run_d = `MWD_RUN_RESET; // RULE15
            end else if (!event_counter_enable) begin
                run_d = `MWD_RUN_RESET; // RULE2
            end else if (step) begin
                if (!qual) begin
                    run_d = `MWD_RUN_RESET;
                end else if (run_q != `MWD_RUN_MAX) begin
                    run_d = run_q + 6'h01;
                end
            end
        end

        always @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
                run_q <= `MWD_RUN_RESET;
            end else begin
                run_q <= run_d;
            end
        end

        // Baseline mode keeps the first sample after re-arm as the reference
        always @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
                ref_q <= {SAMPLE_W{1'b0}};
                have_ref_q <= 1'b0;
            end else if (det_rst) begin
                ref_q <= {SAMPLE_W{1'b0}}; // RULE15
                have_ref_q <= 1'b0;
            end else if (sample_valid_in && (!delta_baseline_q || !have_ref_q)) begin
                ref_q <= cur; // RULE14
                have_ref_q <= 1'b1;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Wake combine and read-back

wire wake_set = combine_all_q ? (&axis_hit) : (|axis_hit); // RULE13

// The reset bit is a level reset, so it wins over a hit in the same cycle
reg wake_d;
always @* begin
    wake_d = wake_q;
    if (det_rst) begin
        wake_d = `MWD_WAKE_RESET; // RULE7
    end else if (wake_set && event_counter_enable) begin
        wake_d = 1'b1; // RULE3
    end
end

always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
        wake_q <= `MWD_WAKE_RESET;
    end else begin
        wake_q <= wake_d;
    end
end

reg [5:0] hid_rd;
always @* begin
    case (hidden_reg_pointer)
        `MWD_PTR_THR_X: hid_rd = thr_flat[5:0];
        `MWD_PTR_THR_Y: hid_rd = thr_flat[11:6];
        `MWD_PTR_THR_Z: hid_rd = thr_flat[17:12];
        `MWD_PTR_CNT_X: hid_rd = cnt_flat[5:0];
        `MWD_PTR_CNT_Y: hid_rd = cnt_flat[11:6];
        `MWD_PTR_CNT_Z: hid_rd = cnt_flat[17:12];
        default: hid_rd = 6'h00;
    endcase
end

reg [7:0] rd_data_d;
always @* begin
    case (reg_addr_in)
        `MWD_ADDR_CONFIG: rd_data_d = config_q;
        `MWD_ADDR_HIDDEN_DATA: rd_data_d = {delta_baseline_q, combine_all_q, hid_rd};
        default: rd_data_d = `MWD_RD_IDLE;
    endcase
end

// Read data is registered, so it follows the address one cycle late
always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
        rd_data_q <= `MWD_RD_RESET;
    end else begin
        rd_data_q <= rd_data_d;
    end
end

assign reg_rd_data_out = rd_data_q;
assign motion_wake_out = wake_q;

endmodule // mwd_motion_wake

// ===== mwd_motion_wake_chk.sv
// Port checker for the motion-wake detector
`timescale 1ns/1ps
module mwd_chk #(parameter SAMPLE_W = 12) (
    // Watched ports
    input wire ref_clk_in,
    input wire reset_in,
    input wire [7:0] reg_addr_in,
    input wire reg_wr_en_in,
    input wire [7:0] reg_wr_data_in,
    input wire [7:0] reg_rd_data_out,
    input wire sample_valid_in,
    input wire [3*SAMPLE_W-1:0] sample_in,
    input wire motion_wake_out
);
    // Shadow of the config register, so gates can be tied to it
    reg [7:0] cfg_q;
    wire wr14 = reg_wr_en_in && reg_addr_in == 8'h14;
    wire wk = motion_wake_out;
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) cfg_q <= 8'h00;
        else if (wr14) cfg_q <= reg_wr_data_in;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    chk_cfg_read_back: assert property (reg_addr_in == 8'h14 && !reg_wr_en_in |=> reg_rd_data_out == $past(cfg_q))
        else $error("config readback wrong");
    chk_unmapped_zero: assert property (reg_addr_in != 8'h13 && reg_addr_in != 8'h14 |=> reg_rd_data_out == 8'h00)
        else $error("unmapped read not zero");
    chk_ptr_none_zero: assert property (reg_addr_in == 8'h13 && !reg_wr_en_in && cfg_q[1:0] == 2'h0 |=> reg_rd_data_out[5:0] == 6'h00)
        else $error("empty pointer read not zero");
    chk_cnten_gate: assert property (!cfg_q[3] && !wk |=> !wk)
        else $error("wake while counters off");
    chk_det_reset_clear: assert property (cfg_q[7] |=> !wk)
        else $error("wake during detector reset");
    chk_wake_holds: assert property (wk && !cfg_q[7] && !(wr14 && reg_wr_data_in[7]) |=> wk)
        else $error("wake dropped");
    chk_wake_cause: assert property ($rose(wk) |-> $past(sample_valid_in))
        else $error("wake without sample");
    chk_reset_quiet: assert property ($fell(reset_in) |-> !wk && reg_rd_data_out == 8'h00)
        else $error("outputs set after reset");
    cover property ($rose(wk));
    cover property (wr14 && reg_wr_data_in[7]);
    cover property (reg_wr_en_in && reg_addr_in == 8'h13);
endmodule // mwd_chk
bind mwd_motion_wake mwd_chk #(.SAMPLE_W(SAMPLE_W)) chk_u (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_en_in(reg_wr_en_in),
    .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_data_out(reg_rd_data_out),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_in),
    .motion_wake_out(motion_wake_out)
);

// ===== mwd_host.sv
// Host model: register writes, reads and the sample stream
`timescale 1ns/1ps
module mwd_host (
    // Clock and read data
    input wire ref_clk_in,
    input wire [7:0] rd_in,
    // Drive
    output reg [7:0] addr_out = 8'h00,
    output reg wr_out = 1'b0,
    output reg [7:0] wdata_out = 8'h00,
    output reg valid_out = 1'b0,
    output reg [35:0] smp_out = 36'h0
);
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk_in);
            {addr_out, wr_out, wdata_out} <= {a, 1'b1, d};
            @(posedge ref_clk_in);
            {wr_out, wdata_out} <= {1'b0, ~d};
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge ref_clk_in);
            addr_out <= a;
            @(posedge ref_clk_in);
            #1 d = rd_in;
        end
    endtask
    task smp(input [35:0] s);
        begin
            @(posedge ref_clk_in);
            {valid_out, smp_out} <= {1'b1, s};
            @(posedge ref_clk_in);
            {valid_out, smp_out} <= {1'b0, ~smp_out};
        end
    endtask
    // Set then clear the detector reset
    task rearm(input [7:0] c);
        begin
            wr(8'h14, c | 8'h80);
            wr(8'h14, c);
        end
    endtask
endmodule // mwd_host

// ===== tb_mwd_motion_wake.sv
// Testbench for the motion-wake detector
`timescale 1ns/1ps
module tb_mwd_motion_wake;
    reg ref_clk_in = 1'b0;
    reg reset_in = 1'b1;
    wire [7:0] addr, wdata, rdata;
    wire wr_en, valid, wake;
    wire [35:0] smp;
    integer mismatches = 0;
    integer n_compared = 0;
    reg [7:0] got;
    always #12.5 ref_clk_in = ~ref_clk_in;
    mwd_host host_u (.ref_clk_in(ref_clk_in), .rd_in(rdata), .addr_out(addr), .wr_out(wr_en),
        .wdata_out(wdata), .valid_out(valid), .smp_out(smp));
    mwd_motion_wake #(.SAMPLE_W(12)) dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(addr),
        .reg_wr_en_in(wr_en), .reg_wr_data_in(wdata), .reg_rd_data_out(rdata), .sample_valid_in(valid),
        .sample_in(smp), .motion_wake_out(wake));
    task chk(input [7:0] g, input [7:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        begin
            host_u.rd(a, got);
            chk(got, e);
        end
    endtask
    // Config c keeps pointer 1, so h lands in the x threshold; h also carries the mode bits
    task det(input [7:0] c, input [7:0] h, input [35:0] s0, input [35:0] s1, input [35:0] s2, input e);
        begin
            host_u.wr(8'h14, c);
            host_u.wr(8'h13, h);
            host_u.rearm(c);
            host_u.smp(s0);
            host_u.smp(s1);
            host_u.smp(s2);
            repeat (2) @(posedge ref_clk_in);
            #1 chk({7'h0, wake}, {7'h0, e});
            $display("Detect test %h done", c);
        end
    endtask
    task wrap_up;
        begin
            $display("Compared %0d, mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rchk(8'h14, 8'h00);
        host_u.wr(8'h14, 8'h01);
        host_u.wr(8'h13, 8'h05);
        rchk(8'h13, 8'h05);
        host_u.wr(8'h14, 8'h04);
        rchk(8'h13, 8'h00);
        rchk(8'h20, 8'h00);
        $display("Register test done");
        det(8'h01, 8'h02, 36'h0, {24'h0, 12'h00a}, {24'h0, 12'h00a}, 1'b0);
        det(8'h09, 8'h02, 36'h0, {24'h0, 12'h00a}, {24'h0, 12'h00a}, 1'b1);
        det(8'h59, 8'h02, 36'h0, {24'h0, 12'h040}, {24'h0, 12'h040}, 1'b0);
        det(8'h59, 8'h02, 36'h0, {24'h0, 12'h060}, {24'h0, 12'h060}, 1'b1);
        det(8'h79, 8'h3e, {24'h0, 12'h800}, {24'h0, 12'h7ff}, {24'h0, 12'h7ff}, 1'b1);
        det(8'h09, 8'h3e, 36'h0, {24'h0, 12'h064}, {24'h0, 12'h064}, 1'b1);
        det(8'h09, 8'h83, 36'h0, {24'h0, 12'h003}, {24'h0, 12'h006}, 1'b1);
        rchk(8'h13, 8'h83);
        det(8'h09, 8'h1c, 36'h0, {24'h0, 12'h014}, {24'h0, 12'h028}, 1'b0);
        det(8'h09, 8'h1c, 36'h0, {24'h0, 12'h028}, {24'h0, 12'h028}, 1'b1);
        det(8'h09, 8'h42, 36'h0, {24'h0, 12'h00a}, {24'h0, 12'h00a}, 1'b0);
        det(8'h09, 8'h42, 36'h0, {12'h005, 12'h005, 12'h00a}, {12'h005, 12'h005, 12'h00a}, 1'b1);
        host_u.wr(8'h14, 8'h0d);
        host_u.wr(8'h13, 8'h01);
        rchk(8'h13, 8'h01);
        det(8'h09, 8'h02, 36'h0, {24'h0, 12'h00a}, {24'h0, 12'h00a}, 1'b0);
        det(8'h09, 8'h02, 36'h0, {24'h0, 12'h00a}, {24'h0, 12'h014}, 1'b1);
        host_u.wr(8'h14, 8'h89);
        rchk(8'h14, 8'h89);
        chk({7'h0, wake}, 8'h00);
        wrap_up;
    end
    // Whole run is a few hundred cycles
    initial begin
        #100000;
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule // tb_mwd_motion_wake
